// file: hdl/gpe_defines.svh
`ifndef GPE_DEFINES_SVH
`define GPE_DEFINES_SVH

// ------------------------------------------------------------------
// Register byte offsets on the register bus
// ------------------------------------------------------------------
`define GPE_OFS_DATA 8'h00
`define GPE_OFS_DIR 8'h04
`define GPE_OFS_PULL 8'h08
`define GPE_OFS_SLEW 8'h0C
`define GPE_OFS_DRIVE 8'h10

// ------------------------------------------------------------------
// Reset values and field layout
// ------------------------------------------------------------------
`define GPE_RST_DATA 8'h00
`define GPE_RST_DIR 8'h00
`define GPE_RST_PULL 8'h00
`define GPE_RST_SLEW 8'h00
`define GPE_RST_DRIVE 8'h00
`define GPE_INPUT_ONLY_BIT 1
`define GPE_OUT_CAPABLE 8'hFD
`define GPE_PORT_WIDTH 8

// ------------------------------------------------------------------
// Bus constants
// ------------------------------------------------------------------
`define GPE_HRESP_OKAY 1'b0
`define GPE_RDATA_ZERO 32'h0000_0000
`define GPE_RDATA_PAD 24'h00_0000

`endif

// file: hdl/gpe_pad_ctrl.sv
`timescale 1ns/10ps
`include "gpe_defines.svh"

module gpe_pad_ctrl (
	input gpe_pkg::gpe_byte_t latch,
	input gpe_pkg::gpe_byte_t dir,
	input gpe_pkg::gpe_byte_t pullEn,
	input gpe_pkg::gpe_byte_t slewEn,
	input gpe_pkg::gpe_byte_t driveSel,
	input gpe_pkg::gpe_byte_t irqPinSelect,
	input gpe_pkg::gpe_byte_t irqEdgeSelect,
	output gpe_pkg::gpe_byte_t pinOut,
	output gpe_pkg::gpe_byte_t pinOe,
	output gpe_pkg::gpe_byte_t pullUpOn,
	output gpe_pkg::gpe_byte_t pullDownOn,
	output gpe_pkg::gpe_byte_t slewOn,
	output gpe_pkg::gpe_byte_t driveHigh
);
	import gpe_pkg::*;

	localparam gpe_byte_t OUT_CAPABLE = `GPE_OUT_CAPABLE;

	genvar k;
	generate
		for (k = 0; k < `GPE_PORT_WIDTH; k++) begin : g_pad
			logic drives;
			logic downReq;
			// The input-only pin has no driver whatever its bit holds.
			assign drives = dir[k] & OUT_CAPABLE[k];
			assign downReq = irqPinSelect[k] & irqEdgeSelect[k];
			assign pinOe[k] = drives;
			assign pinOut[k] = latch[k] & drives;
			// A driving pin never has a pull device on.
			assign pullUpOn[k] = pullEn[k] & ~drives & ~downReq;
			assign pullDownOn[k] = pullEn[k] & ~drives & downReq;
			assign slewOn[k] = slewEn[k] & drives;
			assign driveHigh[k] = driveSel[k] & drives;
		end
	endgenerate

endmodule : gpe_pad_ctrl

// file: hdl/gpe_pin_sync.sv
`timescale 1ns/10ps
`include "gpe_defines.svh"

module gpe_pin_sync (
	input logic clk,
	input logic rst,
	input gpe_pkg::gpe_byte_t pinRaw,
	output gpe_pkg::gpe_byte_t pinSync
);
	import gpe_pkg::*;

	gpe_byte_t stageOne;

	// Pins are asynchronous to clk, so each one passes two flops.
	genvar k;
	generate
		for (k = 0; k < `GPE_PORT_WIDTH; k++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					stageOne[k] <= 1'b0;
					pinSync[k] <= 1'b0;
				end else begin
					stageOne[k] <= pinRaw[k];
					pinSync[k] <= stageOne[k];
				end
			end
		end
	endgenerate

endmodule : gpe_pin_sync

// file: hdl/gpe_pkg.sv
package gpe_pkg;

	typedef logic [7:0] gpe_byte_t;

	typedef enum logic [1:0] {
		GPE_IDLE = 2'b00,
		GPE_WRITE = 2'b01,
		GPE_RDWAIT = 2'b10,
		GPE_RDDONE = 2'b11
	} gpe_bus_state_t;

endpackage : gpe_pkg

// file: hdl/gpe_port.sv
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "gpe_defines.svh"

module gpe_port (
	input logic clk,
	input logic rst,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input gpe_pkg::gpe_byte_t pinIn,
	output gpe_pkg::gpe_byte_t pinOut,
	output gpe_pkg::gpe_byte_t pinOe,
	output gpe_pkg::gpe_byte_t pullUpOn,
	output gpe_pkg::gpe_byte_t pullDownOn,
	output gpe_pkg::gpe_byte_t slewOn,
	output gpe_pkg::gpe_byte_t driveHigh,
	input gpe_pkg::gpe_byte_t irqPinSelect,
	input gpe_pkg::gpe_byte_t irqEdgeSelect
);
	import gpe_pkg::*;

	localparam gpe_byte_t OUT_CAPABLE = `GPE_OUT_CAPABLE;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	gpe_byte_t dataLatch;
	gpe_byte_t direction;
	gpe_byte_t pullEnable;
	gpe_byte_t slewEnable;
	gpe_byte_t driveSelect;
	gpe_byte_t pinSync;
	gpe_byte_t readData;
	gpe_byte_t effDir;

	gpe_bus_state_t state;
	gpe_bus_state_t next_state;
	logic [7:0] addrLatch;
	logic takeAccess;
	logic writeCycle;

	// ------------------------------------------------------------------
	// Pin sampling and pad control
	// ------------------------------------------------------------------
	gpe_pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pinRaw(pinIn),
		.pinSync(pinSync)
	);

	gpe_pad_ctrl u_pad (
		.latch(dataLatch),
		.dir(direction),
		.pullEn(pullEnable),
		.slewEn(slewEnable),
		.driveSel(driveSelect),
		.irqPinSelect(irqPinSelect),
		.irqEdgeSelect(irqEdgeSelect),
		.pinOut(pinOut),
		.pinOe(pinOe),
		.pullUpOn(pullUpOn),
		.pullDownOn(pullDownOn),
		.slewOn(slewOn),
		.driveHigh(driveHigh)
	);

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	// Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored.
	assign takeAccess = hsel & htrans[1] & hready;
	assign writeCycle = (state == GPE_WRITE);
	assign hresp = `GPE_HRESP_OKAY;

	// Reads take one wait state so that hrdata comes from a flop and
	// still sees a write made in the data phase just before.
	assign hreadyout = (state != GPE_RDWAIT);

	always_comb begin
		next_state = state;
		case (state)
			GPE_IDLE, GPE_WRITE, GPE_RDDONE: begin
				if (takeAccess && hwrite) begin
					next_state = GPE_WRITE;
				end else if (takeAccess) begin
					next_state = GPE_RDWAIT;
				end else begin
					next_state = GPE_IDLE;
				end
			end
			GPE_RDWAIT: begin
				next_state = GPE_RDDONE;
			end
			default: begin
				next_state = GPE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= GPE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			addrLatch <= 8'h00;
		end else if (takeAccess && hreadyout) begin
			addrLatch <= haddr[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	// The latch takes every bit, input pins included, so a later switch
	// to output drives what software wrote before.
	always_ff @(posedge clk) begin
		if (rst) begin
			dataLatch <= `GPE_RST_DATA;
		end else if (writeCycle && addrLatch == `GPE_OFS_DATA) begin
			dataLatch <= hwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			direction <= `GPE_RST_DIR;
		end else if (writeCycle && addrLatch == `GPE_OFS_DIR) begin
			direction <= hwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pullEnable <= `GPE_RST_PULL;
		end else if (writeCycle && addrLatch == `GPE_OFS_PULL) begin
			pullEnable <= hwdata[7:0];
		end
	end

	// Software is expected to rewrite this after reset; the reset value
	// is only a safe default.
	always_ff @(posedge clk) begin
		if (rst) begin
			slewEnable <= `GPE_RST_SLEW;
		end else if (writeCycle && addrLatch == `GPE_OFS_SLEW) begin
			slewEnable <= hwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			driveSelect <= `GPE_RST_DRIVE;
		end else if (writeCycle && addrLatch == `GPE_OFS_DRIVE) begin
			driveSelect <= hwdata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------
	// Bit one can never drive, so it always reads the pin.
	assign effDir = direction & OUT_CAPABLE;

	always_comb begin
		case (addrLatch)
			`GPE_OFS_DATA: begin
				readData = (effDir & dataLatch) | (~effDir & pinSync);
			end
			`GPE_OFS_DIR: begin
				readData = direction;
			end
			`GPE_OFS_PULL: begin
				readData = pullEnable;
			end
			`GPE_OFS_SLEW: begin
				readData = slewEnable;
			end
			`GPE_OFS_DRIVE: begin
				readData = driveSelect;
			end
			default: begin
				readData = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= `GPE_RDATA_ZERO;
		end else if (state == GPE_RDWAIT) begin
			hrdata <= {`GPE_RDATA_PAD, readData};
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic readOfData;
	assign readOfData = (state == GPE_RDWAIT) && (addrLatch == `GPE_OFS_DATA);

	chk_input_pin_read: assert property (
		readOfData |=> ((hrdata[7:0] ^ $past(pinSync)) & ~$past(effDir)) == 8'h00
	) else $error("input pin read does not show pin level");

	chk_output_pin_read: assert property (
		readOfData |=> ((hrdata[7:0] ^ $past(dataLatch)) & $past(effDir)) == 8'h00
	) else $error("output pin read does not show latch");

	chk_latch_write: assert property (
		(writeCycle && addrLatch == `GPE_OFS_DATA)
			|=> dataLatch == $past(hwdata[7:0]) ##0 pinOut == (dataLatch & pinOe)
	) else $error("data write not latched or not driven");

	chk_reset_state: assert property (
		$fell(rst) |-> dataLatch == 8'h00 && pinOe == 8'h00
			&& pullUpOn == 8'h00 && pullDownOn == 8'h00
	) else $error("reset left a pin driven or pulled");

	chk_bit_one_read: assert property (
		readOfData |=> hrdata[`GPE_INPUT_ONLY_BIT] == $past(pinSync[1])
	) else $error("bit one read not from pin");

	chk_direction_drive: assert property (
		(direction[0] && !$past(direction[0])) |-> pinOe[0] ##0 pinOut[0] == dataLatch[0]
	) else $error("direction bit did not enable driver");

	chk_input_only_pin: assert property (
		(writeCycle && addrLatch == `GPE_OFS_DIR && hwdata[1])
			|=> direction[1] && !pinOe[1]
	) else $error("input-only pin driven or bit lost");

	chk_bit_one_pad: assert property (
		slewEnable[1] |-> !slewOn[1] && !driveHigh[1]
	) else $error("slew or drive active on input-only pin");

	chk_pullup_on: assert property (
		(pullEnable[0] && !direction[0] && !pullDownOn[0]) |-> pullUpOn[0]
	) else $error("pull-up missing on enabled input");

	chk_output_no_pull: assert property (
		((pullUpOn | pullDownOn) & pinOe) == 8'h00
	) else $error("pull device on a driving pin");

	chk_pulldown_cond: assert property (
		(pullDownOn & ~(irqPinSelect & irqEdgeSelect)) == 8'h00
	) else $error("pull-down without interrupt select");

	chk_slew_gated: assert property (
		(slewEnable[2] && direction[2]) |-> slewOn[2] ##0 (slewOn & ~pinOe) == 8'h00
	) else $error("slew control wrong for pin direction");

	chk_drive_gated: assert property (
		(driveSelect[3] && !direction[3]) |-> !driveHigh[3]
	) else $error("drive select acted on an input");

	chk_read_one_wait: assert property (
		(takeAccess && hreadyout && !hwrite)
			|=> !hreadyout ##1 hreadyout && hresp == `GPE_HRESP_OKAY
	) else $error("read did not finish after one wait state");

	chk_write_no_wait: assert property (
		(takeAccess && hreadyout && hwrite) |=> hreadyout
	) else $error("write inserted a wait state");

	chk_dir_readback: assert property (
		(state == GPE_RDWAIT && addrLatch == `GPE_OFS_DIR)
			|=> hrdata == {`GPE_RDATA_PAD, $past(direction)}
	) else $error("direction register read back wrong");

	chk_unmapped_read: assert property (
		(state == GPE_RDWAIT && addrLatch > `GPE_OFS_DRIVE)
			|=> hrdata == `GPE_RDATA_ZERO
	) else $error("unmapped register did not read zero");

endmodule : gpe_port

// file: tb/gpe_pin_model.sv
`timescale 1ns/10ps

module gpe_pin_model (
	input logic clk,
	input gpe_pkg::gpe_byte_t pinOut,
	input gpe_pkg::gpe_byte_t pinOe,
	input gpe_pkg::gpe_byte_t pullUpOn,
	input gpe_pkg::gpe_byte_t pullDownOn,
	input gpe_pkg::gpe_byte_t extLevel,
	input gpe_pkg::gpe_byte_t extEn,
	output gpe_pkg::gpe_byte_t pinIn
);
	import gpe_pkg::*;

	gpe_byte_t floatPat = 8'h5A;

	// An undriven, unpulled pin toggles every cycle, so that no check can
	// lean on a level that a floating board line would never promise.
	always @(posedge clk) begin
		floatPat <= ~floatPat;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pinOe[i])
				pinIn[i] = pinOut[i];
			else if (extEn[i])
				pinIn[i] = extLevel[i];
			else if (pullUpOn[i])
				pinIn[i] = 1'b1;
			else if (pullDownOn[i])
				pinIn[i] = 1'b0;
			else
				pinIn[i] = floatPat[i];
		end
	end

endmodule : gpe_pin_model

// file: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
	import gpe_pkg::*;

	logic clk, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	gpe_byte_t pinIn, pinOut, pinOe, pullUpOn, pullDownOn, slewOn, driveHigh;
	gpe_byte_t irqSel, irqEdge, extLevel, extEn;
	gpe_byte_t cfg[5];
	int failCount = 0;
	int nChecks = 0;

	gpe_port i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pullUpOn(pullUpOn), .pullDownOn(pullDownOn), .slewOn(slewOn),
		.driveHigh(driveHigh), .irqPinSelect(irqSel),
		.irqEdgeSelect(irqEdge));

	gpe_pin_model i_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
		.pullUpOn(pullUpOn), .pullDownOn(pullDownOn), .extLevel(extLevel),
		.extEn(extEn), .pinIn(pinIn));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task finishTest;
		if (failCount == 0 && nChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finishTest

	task check(input string what, input logic [47:0] exp, got, mask);
		nChecks++;
		if (((got ^ exp) & mask) !== 48'h0) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			failCount++;
		end
	endtask : check

	task waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			$display("ERROR hreadyout expected 1 seen %b", hreadyout);
			failCount++;
			finishTest();
		end
	endtask : waitReady

	task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, addr};
		hwrite <= wr;
		waitReady();
		htrans <= 2'b00;
		hwdata <= wd;
		waitReady();
		rd = hrdata;
		check("hresp", 48'h0, {47'h0, hresp}, 48'h1);
	endtask : bus

	// Pin level the board shows and which bits of it are predictable.
	function automatic logic [15:0] expLevel(gpe_byte_t d, l, pe, s, e,
			x, xe);
		gpe_byte_t oe, pu, pd;
		oe = d & 8'hFD;
		pd = pe & ~oe & s & e;
		pu = pe & ~oe & ~(s & e);
		return {(oe & l) | (~oe & xe & x) | (~oe & ~xe & pu),
			oe | xe | pu | pd};
	endfunction : expLevel

	function automatic logic [47:0] expPads(gpe_byte_t d, l, pe, sl, dr,
			s, e);
		gpe_byte_t oe;
		oe = d & 8'hFD;
		return {oe, l & oe, pe & ~oe & ~(s & e), pe & ~oe & s & e,
			sl & oe, dr & oe};
	endfunction : expPads

	task checkPads(input logic [47:0] exp);
		check("pads", exp, {pinOe, pinOut, pullUpOn, pullDownOn, slewOn,
			driveHigh}, {48{1'b1}});
	endtask : checkPads

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] lv;
		logic [47:0] padExp;
		gpe_byte_t sel, edg, lvl, en;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		irqSel = 8'h00;
		irqEdge = 8'h00;
		extLevel = 8'h00;
		extEn = 8'hFF;
		void'($urandom(31));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 checkPads(48'h0);
		@(posedge clk);
		for (int r = 1; r < 6; r++) begin
			bus(1'b0, 8'(r * 4), 32'h0);
			check("reset reg", 48'h0, {16'h0, rd}, {48{1'b1}});
		end
		bus(1'b1, 8'h0C, 32'h0000_0000);
		for (int i = 0; i < 40; i++) begin
			foreach (cfg[r])
				cfg[r] = gpe_byte_t'($urandom);
			sel = gpe_byte_t'($urandom);
			edg = gpe_byte_t'($urandom);
			lvl = gpe_byte_t'($urandom);
			en = gpe_byte_t'($urandom);
			if (i == 0) begin
				cfg = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
				lvl = 8'h00;
				en = 8'h02;
				sel = 8'h00;
			end else if (i == 1) begin
				cfg = '{8'hAA, 8'h00, 8'hFF, 8'h0F, 8'hF0};
				en = 8'h00;
				sel = 8'hF0;
				edg = 8'h3C;
			end
			// The board never fights a pin that the port drives.
			en = en & ~(cfg[1] & 8'hFD);
			irqSel <= sel;
			irqEdge <= edg;
			extLevel <= lvl;
			extEn <= en;
			for (int r = 0; r < 5; r++)
				bus(1'b1, 8'(r * 4), {24'($urandom), cfg[r]});
			repeat (3) @(posedge clk);
			padExp = expPads(cfg[1], cfg[0], cfg[2], cfg[3], cfg[4],
				irqSel, irqEdge);
			#1 checkPads(padExp);
			@(posedge clk);
			lv = expLevel(cfg[1], cfg[0], cfg[2], irqSel, irqEdge, extLevel,
				extEn);
			bus(1'b0, 8'h00, 32'h0);
			check("data", {40'h0, lv[15:8]}, {16'h0, rd},
				{24'hFF_FFFF, lv[7:0]});
			for (int r = 1; r < 5; r++) begin
				bus(1'b0, 8'(r * 4), 32'h0);
				check("reg", {40'h0, cfg[r]}, {16'h0, rd},
					{48{1'b1}});
			end
			bus(1'b1, 8'h14, 32'hFFFF_FFFF);
			bus(1'b0, 8'h14, 32'h0);
			check("unmapped", 48'h0, {16'h0, rd}, {48{1'b1}});
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 checkPads(48'h0);
		@(posedge clk);
		bus(1'b1, 8'h0C, 32'h0000_0000);
		bus(1'b1, 8'h04, 32'h0000_00FF);
		repeat (3) @(posedge clk);
		#1 check("latch out", 48'h0, {40'h0, pinOut}, {48{1'b1}});
		@(posedge clk);
		finishTest();
	end

endmodule : testbench
